//--- verilog/slcd_defs.svh
// Constants of the segment display memory and driver block.
`ifndef SLCD_DEFS_SVH
`define SLCD_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------------------
`define SLCD_IDX_BANK       7'h04
`define SLCD_IDX_DISP_FIRST 7'h40
`define SLCD_IDX_DISP_LAST  7'h53
`define SLCD_IDX_STATUS     7'h7F
`define SLCD_ADR_IDX_HI     8
`define SLCD_ADR_IDX_LO     2
`define SLCD_ADR_INDIRECT   9
`define SLCD_BANK_RESET     8'h00
`define SLCD_BANK_DISP      1'b1
`define SLCD_BANK_BIT       0

// ----------------------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------------------
`define SLCD_SEGS           20
`define SLCD_COM_PINS       3
`define SLCD_COMMONS_DEF    3
`define SLCD_CLK_HZ         40000000
`define SLCD_OSC_HZ         32768
`define SLCD_OSC_DIV        128
`define SLCD_STEP_CYCLES    (`SLCD_CLK_HZ / (`SLCD_OSC_HZ / `SLCD_OSC_DIV))

// ----------------------------------------------------------------------------
// Drive level codes, in steps of the bias fraction of the panel voltage
// ----------------------------------------------------------------------------
`define SLCD_LVL_GND        2'h0
`define SLCD_LVL_ONE        2'h1
`define SLCD_LVL_TWO        2'h2
`define SLCD_LVL_THREE      2'h3

`endif

//--- verilog/slcd_pkg.sv
// Types shared by the segment display driver modules.
package slcd_pkg;

	typedef enum logic [1:0]
	{
		SLCD_BUS_IDLE = 2'b00,
		SLCD_BUS_ACK  = 2'b01
	} slcd_bus_e;

	typedef logic [1:0] slcd_lvl_t;
	typedef logic [1:0] slcd_com_t;
	typedef logic [3:0] slcd_nib_t;

endpackage : slcd_pkg

//--- verilog/slcd_frame_if.sv
// Frame timing carried from the frame generator to the driver.
`timescale 1ns/10ps
interface slcd_frame_if;
	logic                step;
	slcd_pkg::slcd_com_t com_idx;
	logic                phase;

	modport gen (output step, output com_idx, output phase);
	modport drv (input step, input com_idx, input phase);
endinterface : slcd_frame_if

//--- verilog/slcd_frame_gen.sv
// Frame timing generator: common stepping and drive phase.
`timescale 1ns/10ps
`include "slcd_defs.svh"
module slcd_frame_gen
#(
	parameter int COMMONS     = `SLCD_COMMONS_DEF,
	parameter int STEP_CYCLES = `SLCD_STEP_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	slcd_frame_if.gen frm
);
	import slcd_pkg::*;

	logic [31:0] div_reg;

	// ------------------------------------------------------------------------
	// Oscillator divider
	// ------------------------------------------------------------------------
	// One step per divided oscillator period; the count is a parameter so a
	// simulation can shorten the frame.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			div_reg  <= '0;
			frm.step <= 1'b0;
		end
		else if (ce)
		begin
			if (div_reg == 32'(STEP_CYCLES - 1))
			begin
				div_reg  <= '0;
				frm.step <= 1'b1;
			end
			else
			begin
				div_reg  <= div_reg + 32'd1;
				frm.step <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Common scan and phase
	// ------------------------------------------------------------------------
	// The phase flips after every full scan, so each pin spends as long at
	// one polarity as at the other and the panel sees no mean DC.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			frm.com_idx <= '0;
			frm.phase   <= 1'b0;
		end
		else if (ce && frm.step)
		begin
			if (frm.com_idx == slcd_com_t'(COMMONS - 1))
			begin
				frm.com_idx <= '0;
				frm.phase   <= ~frm.phase;
			end
			else
			begin
				frm.com_idx <= frm.com_idx + slcd_com_t'(1);
			end
		end
	end

endmodule : slcd_frame_gen

//--- verilog/slcd_driver.sv
// Segment display memory with Wishbone access and panel waveform driver.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
`include "slcd_defs.svh"
module slcd_driver
#(
	parameter int COMMONS         = `SLCD_COMMONS_DEF,
	parameter bit OFF_IN_HALT     = 1'b0,
	parameter int STEP_CYCLES     = `SLCD_STEP_CYCLES
)
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        halt,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [9:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic      [31:0] wb_dat_r,
	output logic             wb_ack,
	output logic [2*`SLCD_SEGS-1:0]    seg_level,
	output logic [2*`SLCD_COM_PINS-1:0] com_level,
	output slcd_pkg::slcd_nib_t status
);
	import slcd_pkg::*;

	localparam bit FOUR_COM = (COMMONS == 4);

	slcd_frame_if frm ();

	slcd_bus_e   bus_reg;
	logic [7:0]  bank_reg;
	slcd_nib_t   disp_mem [`SLCD_SEGS];
	logic [6:0]  idx;
	logic        indirect;
	logic        active;

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------
	// True when an access lands in the display memory.
	function automatic logic is_disp(input logic [6:0] a, input logic ind,
		input logic bank);
		logic hit;
		hit = ind && (bank == `SLCD_BANK_DISP) &&
			(a >= `SLCD_IDX_DISP_FIRST) && (a <= `SLCD_IDX_DISP_LAST);
		if (FOUR_COM && (a == `SLCD_IDX_DISP_LAST))
			hit = 1'b0;
		return hit;
	endfunction : is_disp

	// Segment level for one phase: an on segment sits opposite the selected
	// common, an off segment matches it at 1/2 bias and sits one bias step away at 1/3.
	function automatic slcd_lvl_t seg_lvl(input logic on, input logic ph);
		slcd_lvl_t l;
		l = `SLCD_LVL_GND;
		if (FOUR_COM)
			l = ph ? (on ? `SLCD_LVL_THREE : `SLCD_LVL_ONE)
				: (on ? `SLCD_LVL_GND : `SLCD_LVL_TWO);
		else
			l = (on ^ ph) ? `SLCD_LVL_GND : `SLCD_LVL_TWO;
		return l;
	endfunction : seg_lvl

	// Common level for one phase, selected or resting.
	function automatic slcd_lvl_t com_lvl(input logic sel, input logic ph);
		slcd_lvl_t l;
		l = `SLCD_LVL_ONE;
		if (sel)
			l = ph ? `SLCD_LVL_GND : (FOUR_COM ? `SLCD_LVL_THREE
				: `SLCD_LVL_TWO);
		else if (FOUR_COM)
			l = ph ? `SLCD_LVL_TWO : `SLCD_LVL_ONE;
		return l;
	endfunction : com_lvl

	assign idx      = wb_adr[`SLCD_ADR_IDX_HI:`SLCD_ADR_IDX_LO];
	assign indirect = wb_adr[`SLCD_ADR_INDIRECT];
	assign active   = !(OFF_IN_HALT && halt);

	// ------------------------------------------------------------------------
	// Frame timing
	// ------------------------------------------------------------------------
	slcd_frame_gen
	#(
		.COMMONS     (COMMONS),
		.STEP_CYCLES (STEP_CYCLES)
	)
	u_frame
	(
		.clk_sys (clk_sys),
		.reset   (reset),
		.ce      (ce),
		.frm     (frm.gen)
	);

	// ------------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------------
	// Ack comes one cycle after the request is seen and drops the cycle after;
	// a write lands on the edge where the master samples the ack.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			bus_reg  <= SLCD_BUS_IDLE;
			wb_ack   <= 1'b0;
			wb_dat_r <= '0;
		end
		else if (ce)
		begin
			case (bus_reg)
				SLCD_BUS_IDLE:
				begin
					if (wb_cyc && wb_stb)
					begin
						bus_reg  <= SLCD_BUS_ACK;
						wb_ack   <= 1'b1;
						wb_dat_r <= '0;
						if (idx == `SLCD_IDX_BANK)
							wb_dat_r[7:0] <= bank_reg;
						else if (idx == `SLCD_IDX_STATUS)
							wb_dat_r[3:0] <= status;
						else if (is_disp(idx, indirect,
							bank_reg[`SLCD_BANK_BIT]))
							wb_dat_r[3:0] <= disp_mem[5'(idx
								- `SLCD_IDX_DISP_FIRST)];
					end
				end
				SLCD_BUS_ACK:
				begin
					bus_reg <= SLCD_BUS_IDLE;
					wb_ack  <= 1'b0;
				end
				default:
				begin
					bus_reg <= SLCD_BUS_IDLE;
					wb_ack  <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Bank select register
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			bank_reg <= `SLCD_BANK_RESET;
		else if (ce && wb_ack && wb_cyc && wb_stb && wb_we && wb_sel[0]
			&& (idx == `SLCD_IDX_BANK))
			bank_reg <= wb_dat_w[7:0];
	end

	// ------------------------------------------------------------------------
	// Display memory
	// ------------------------------------------------------------------------
	// Left out of reset on purpose: like the RAM it models, its contents are
	// unknown until software fills it.
	always_ff @(posedge clk_sys)
	begin
		if (ce && wb_ack && wb_cyc && wb_stb && wb_we && wb_sel[0]
			&& is_disp(idx, indirect, bank_reg[`SLCD_BANK_BIT]))
			disp_mem[5'(idx - `SLCD_IDX_DISP_FIRST)] <= wb_dat_w[3:0];
	end

	// ------------------------------------------------------------------------
	// Segment waveforms
	// ------------------------------------------------------------------------
	// Levels are rebuilt every enabled cycle straight from memory, so a write
	// shows on the panel without any core action.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			seg_level <= '0;
		else if (ce)
		begin
			for (int s = 0; s < `SLCD_SEGS; s++)
			begin
				if (!active)
					seg_level[2*s +: 2] <= `SLCD_LVL_GND;
				else if (FOUR_COM && (s == `SLCD_SEGS - 1))
					seg_level[2*s +: 2] <= com_lvl(
						frm.com_idx == 2'd3, frm.phase);
				else
					seg_level[2*s +: 2] <= seg_lvl(
						disp_mem[s][frm.com_idx], frm.phase);
			end
		end
	end

	// ------------------------------------------------------------------------
	// Common waveforms
	// ------------------------------------------------------------------------
	// Commons beyond the chosen count rest at ground.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			com_level <= '0;
		else if (ce)
		begin
			for (int c = 0; c < `SLCD_COM_PINS; c++)
			begin
				if (!active || (c >= COMMONS))
					com_level[2*c +: 2] <= `SLCD_LVL_GND;
				else
					com_level[2*c +: 2] <= com_lvl(
						frm.com_idx == 2'(c), frm.phase);
			end
		end
	end

	// ------------------------------------------------------------------------
	// Status
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			status <= '0;
		else if (ce)
			status <= {active, frm.phase, frm.com_idx};
	end

endmodule : slcd_driver

//--- testbench/slcd_panel_model.sv
// Glass panel model that records which pixels see drive voltage.
`timescale 1ns/10ps
module slcd_panel_model
(
	input wire logic        clk_sys,
	input wire logic [39:0] seg_level,
	input wire logic [5:0]  com_level,
	output logic     [59:0] pix
);
	logic [5:0] com_prev_reg;

	// A pixel is lit when its segment differs from its selected common.
	// Only settled commons are sampled, so a step never leaves half data.
	always_ff @(posedge clk_sys)
	begin
		com_prev_reg <= com_level;
		for (int c = 0; c < 3; c++)
			if (com_level[2*c+:2] != 2'h1 && com_level == com_prev_reg)
				for (int s = 0; s < 20; s++)
					pix[c*20+s] <= seg_level[2*s+:2] != com_level[2*c+:2];
	end
endmodule : slcd_panel_model

//--- testbench/slcd_driver_monitor.sv
// Concurrent checks on the display driver ports.
`timescale 1ns/10ps
module slcd_driver_monitor
#(
	parameter int COMMONS     = 3,
	parameter int STEP_CYCLES = 8
)
(
	input wire logic                clk_sys,
	input wire logic                reset,
	input wire logic                ce,
	input wire logic                wb_cyc,
	input wire logic                wb_stb,
	input wire logic                wb_we,
	input wire logic [9:0]          wb_adr,
	input wire logic [31:0]         wb_dat_r,
	input wire logic                wb_ack,
	input wire logic [39:0]         seg_level,
	input wire logic [5:0]          com_level,
	input wire slcd_pkg::slcd_nib_t status
);
	import slcd_pkg::*;
	logic [15:0] gap_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// One plus the enabled edges since the last common step; zero before
	// the first. A step is seen one edge after it lands, and that edge may
	// have the enable low, so it only counts when enabled.
	always_ff @(posedge clk_sys)
		gap_reg <= reset ? 16'h0 :
			$changed(status[1:0]) ? (ce ? 16'h2 : 16'h1) :
			gap_reg + {15'h0, ce && gap_reg != 16'h0};

	sequence s_take;
		ce && wb_cyc && $rose(wb_stb);
	endsequence
	sequence s_pulse;
		wb_ack ##1 !wb_ack;
	endsequence

	AST_ACK_PULSE: assert property (s_take |=> s_pulse)
		else $error("ack is not a single pulse");
	AST_ACK_CAUSE: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
		else $error("ack without request");
	AST_RD_UPPER: assert property (wb_ack |-> wb_dat_r[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_DIRECT_DISP: assert property (s_take ##0 (!wb_we && !wb_adr[9]
		&& wb_adr[8:2] >= 7'h40 && wb_adr[8:2] <= 7'h53)
		|=> wb_dat_r == 32'h0) else $error("direct read reached display");
	AST_SEG_BIAS: assert property ((COMMONS < 4)
		|-> (seg_level & {20{2'h1}}) == 40'h0)
		else $error("segment level off half bias");
	AST_COM_BIAS: assert property ((COMMONS < 4)
		|-> (com_level & (com_level >> 1) & 6'h15) == 6'h0)
		else $error("common level off half bias");
	AST_COM_RANGE: assert property (status[1:0] < COMMONS)
		else $error("common index out of range");
	AST_PHASE_FLIP: assert property ($changed(status[2])
		|-> $past(status[1:0]) == COMMONS - 1)
		else $error("phase flipped before last common");
	AST_STEP_GAP: assert property ($changed(status[1:0])
		&& gap_reg != 16'h0 |-> gap_reg == STEP_CYCLES + 1)
		else $error("common step spacing wrong");
	AST_CE_FREEZE: assert property (!ce
		|=> $stable(status) && $stable(seg_level))
		else $error("state moved with enable low");
endmodule : slcd_driver_monitor

bind slcd_driver slcd_driver_monitor
	#(.COMMONS(COMMONS), .STEP_CYCLES(STEP_CYCLES)) u_mon
	(.clk_sys, .reset, .ce, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
	.wb_dat_r, .wb_ack, .seg_level, .com_level, .status);

//--- testbench/tb_top.sv
// Self-checking bench for the segment display driver.
`timescale 1ns/10ps
module tb_top;
	logic        clk_sys = 1'h0;
	logic        reset = 1'h1;
	logic        ce = 1'h1;
	logic        halt = 1'h0;
	logic        wb_cyc = 1'h0;
	logic        wb_stb = 1'h0;
	logic        wb_we = 1'h0;
	logic [9:0]  wb_adr = 10'h0;
	logic [3:0]  wb_sel = 4'hF;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r;
	logic        wb_ack;
	logic [39:0] seg_level;
	logic [5:0]  com_level;
	logic [59:0] pix;
	logic [31:0] wb_dat_r4;
	logic        wb_ack4;
	logic [39:0] seg_level4;
	logic [5:0]  com_level4;
	logic [3:0]  status;
	logic [3:0]  status4;
	logic [31:0] rd4;
	logic [31:0] rd;
	logic [7:0]  d;
	logic [3:0]  mem [20];
	int          fails = 0;
	int          compares = 0;
	int          seed = 38;

	// Clock of 25 ns period.
	always #12.5 clk_sys = ~clk_sys;

	slcd_driver #(.COMMONS(3), .OFF_IN_HALT(1'h0), .STEP_CYCLES(8)) u_dut
	(.clk_sys, .reset, .ce, .halt, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
	.wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .seg_level, .com_level,
	.status);

	// Second build on the same bus: four commons, 1/3 bias, off in halt.
	slcd_driver #(.COMMONS(4), .OFF_IN_HALT(1'h1), .STEP_CYCLES(8))
		u_dut_four
	(.clk_sys, .reset, .ce, .halt, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
	.wb_sel, .wb_dat_w, .wb_dat_r(wb_dat_r4), .wb_ack(wb_ack4),
	.seg_level(seg_level4), .com_level(com_level4), .status(status4));

	slcd_panel_model u_panel (.clk_sys, .seg_level, .com_level, .pix);

	function automatic logic [9:0] ad(input logic ind, input logic [6:0] i);
		return {ind, i, 2'h0};
	endfunction : ad

	// Pixel c of segment s shows bit c of entry s.
	function automatic logic [59:0] exp_pix();
		for (int c = 0; c < 3; c++)
			for (int s = 0; s < 20; s++)
				exp_pix[c*20+s] = mem[s][c];
	endfunction : exp_pix

	// Segment level: an on segment faces the selected common, an off one
	// matches it at 1/2 bias and sits one bias step from it at 1/3; third picks the 1/3 bias build.
	function automatic logic [1:0] exp_seg(input logic on, input logic ph,
		input logic third);
		if (third)
			return ph ? (on ? 2'h3 : 2'h1) : (on ? 2'h0 : 2'h2);
		return (on ^ ph) ? 2'h0 : 2'h2;
	endfunction : exp_seg

	// Common level, selected or resting, for either bias.
	function automatic logic [1:0] exp_com(input logic sel, input logic ph,
		input logic third);
		if (sel)
			return ph ? 2'h0 : (third ? 2'h3 : 2'h2);
		return third ? (ph ? 2'h2 : 2'h1) : 2'h1;
	endfunction : exp_com

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Compare of the lit pixels seen by the panel.
	task automatic chk_pix(input logic [59:0] got, input logic [59:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_pix

	// Compare of drive level codes and status bits.
	task automatic chk_lvl(input logic [45:0] got, input logic [45:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_lvl

	// One classic cycle; held until ack is sampled, then released.
	task automatic wb(input logic w, input logic [9:0] a,
		input logic [7:0] dd, input logic [3:0] s);
		@(posedge clk_sys);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat_w <= {24'h0, dd};
		do @(posedge clk_sys); while (wb_ack !== 1'h1);
		rd = wb_dat_r;
		rd4 = wb_dat_r4;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
	endtask : wb

	task automatic results();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	// Watchdog well beyond the expected run of about 700 cycles.
	initial
	begin
		#(25 * 8000);
		fails++;
		results();
	end

	// Register checks, then random and corner patterns on the panel.
	initial
	begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'h0;
		wb(0, ad(0, 7'h04), 8'h0, 4'hF);
		chk(rd, 0);
		wb(1, ad(0, 7'h04), 8'hA5, 4'hF);
		wb(0, ad(0, 7'h04), 8'h0, 4'hF);
		chk(rd, 8'hA5);
		for (int r = 0; r < 3; r++)
		begin
			for (int s = 0; s < 20; s++)
			begin
				d = (r == 2) ? 8'h0F : 8'($random(seed));
				mem[s] = d[3:0];
				wb(1, ad(1, 7'h40 + 7'(s)), d, 4'hF);
			end
			halt <= (r == 1);
			repeat (100) @(posedge clk_sys);
			chk_pix(pix, exp_pix());
			chk_lvl(status[3], 1'h1);
			// Levels and status leave the same edge, so they agree here.
			chk_lvl(seg_level[1:0],
				exp_seg(mem[0][status[1:0]], status[2], 1'h0));
			chk_lvl(com_level[1:0],
				exp_com(status[1:0] == 2'h0, status[2], 1'h0));
			if (r == 1)
			begin
				chk_lvl({seg_level4, com_level4}, 46'h0);
				chk_lvl(status4[3], 1'h0);
			end
			else
			begin
				chk_lvl(seg_level4[1:0],
					exp_seg(mem[0][status4[1:0]], status4[2], 1'h1));
				chk_lvl(seg_level4[39:38],
					exp_com(status4[1:0] == 2'h3, status4[2], 1'h1));
			end
		end
		for (int s = 0; s < 20; s++)
		begin
			wb(0, ad(1, 7'h40 + 7'(s)), 8'h0, 4'hF);
			chk(rd, mem[s]);
			chk(rd4, (s == 19) ? 4'h0 : mem[s]);
		end
		wb(0, ad(0, 7'h40), 8'h0, 4'hF);
		chk(rd, 0);
		wb(1, ad(0, 7'h40), 8'h00, 4'hF);
		wb(1, ad(1, 7'h41), 8'h00, 4'hE);
		wb(1, ad(0, 7'h04), 8'hFE, 4'hF);
		wb(0, ad(1, 7'h42), 8'h0, 4'hF);
		chk(rd, 0);
		wb(1, ad(1, 7'h42), 8'h00, 4'hF);
		wb(1, ad(0, 7'h04), 8'h01, 4'hF);
		for (int s = 0; s < 3; s++)
		begin
			wb(0, ad(1, 7'h40 + 7'(s)), 8'h0, 4'hF);
			chk(rd, mem[s]);
		end
		wb(0, ad(1, 7'h20), 8'h0, 4'hF);
		chk(rd, 0);
		ce <= 1'h0;
		repeat (10) @(posedge clk_sys);
		ce <= 1'h1;
		repeat (100) @(posedge clk_sys);
		chk_pix(pix, exp_pix());
		results();
	end
endmodule : tb_top
